// ### rtl/rbc_pkg.sv
package rbc_pkg;

    // machine cycle length in system clocks
    localparam int MC_DIV_DEF = 4;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // control register slots, each one aligned word
    localparam int              CTRL_NUM       = 14;
    localparam logic [7:0]      ADDR_CTRL_BASE = 8'h00;
    localparam logic [7:0]      ADDR_FLAGS     = 8'h38;
    localparam logic [7:0]      ADDR_STATUS    = 8'h3c;
    localparam logic [7:0]      ADDR_STACK     = 8'h40;
    localparam logic [7:0]      ADDR_WDT       = 8'h44;

    // slot indices of the control registers
    localparam int IDX_CLOCK_CTRL = 0;   // clock_control_reg
    localparam int IDX_CONV_CTRL  = 1;   // converter_control_reg
    localparam int IDX_EXT_IRQ    = 2;   // ext_irq_control_reg
    localparam int IDX_IRQ_ONE    = 3;   // irq_control_reg_one
    localparam int IDX_IRQ_TWO    = 4;   // irq_control_reg_two
    localparam int IDX_TMR_ONE    = 5;   // timer_control_one
    localparam int IDX_TMR_TWO    = 6;   // timer_control_two
    localparam int IDX_TMR_SIX    = 7;   // timer_control_six
    localparam int IDX_WAKE_ZERO  = 8;   // wakeup_ctrl_zero
    localparam int IDX_WAKE_ONE   = 9;   // wakeup_ctrl_one
    localparam int IDX_WAKE_TWO   = 10;  // wakeup_ctrl_two
    localparam int IDX_PU_ZERO    = 11;  // pullup_ctrl_zero
    localparam int IDX_PU_ONE     = 12;  // pullup_ctrl_one
    localparam int IDX_PU_TWO     = 13;  // pullup_ctrl_two

    // reset values, slot 13 down to slot 0
    localparam logic [3:0]  CLOCK_CTRL_RST = 4'hc;
    localparam logic [3:0]  ZERO_RST       = 4'h0;
    localparam logic [55:0] CTRL_RST_VEC   = {{13{ZERO_RST}}, CLOCK_CTRL_RST};
    // slots kept across ram retention, one bit per slot
    localparam logic [13:0] CTRL_RETAIN    = 14'h3fc6;

    // bit positions inside the control registers
    localparam int EXT_IRQ_LEVEL_BIT = 2;  // return level of the int pin
    localparam int WAKE_ONE_SEL_BIT  = 3;  // 1: p13 key, 0: int pin

    // stack pointer start value
    localparam logic [2:0] STACK_INIT = 3'h7;

    // flags kept across ram retention (timer two and second watchdog)
    localparam logic [8:0] FLAG_WARM_KEEP = 9'h028;
    localparam logic [8:0] FLAG_RST       = 9'h000;

    localparam logic [15:0] WDT_RST = 16'h0000;
    localparam logic [15:0] WDT_TOP = 16'hffff;

    typedef enum logic [2:0] {
        INS_OTHER       = 3'b000,
        INS_SLEEP_ARM   = 3'b001,   // sleep_arm_instr
        INS_SLEEP_ENTER = 3'b010,   // sleep_enter_instr
        INS_SKIP_PD     = 3'b011,   // skip_if_powerdown_flag
        INS_WDT_RESTART = 3'b100    // watchdog_restart_instr
    } rbc_instr_t;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_RUN   = 2'b01,
        ST_SLEEP = 2'b10
    } rbc_state_t;

    typedef struct packed {
        logic irqEnable;   // global_irq_enable
        logic extReq;      // ext_irq_request_flag
        logic tmr1Req;     // timer_one_request_flag
        logic tmr2Req;     // timer_two_request_flag
        logic wdFirst;     // watchdog_flag_first
        logic wdSecond;    // watchdog_flag_second
        logic wdEnable;    // watchdog_enable_flag
        logic convDone;    // conversion_done_flag
        logic carry;       // carry_flag
    } rbc_flags_t;

endpackage : rbc_pkg

// ### rtl/rbc_sync.sv
`timescale 1ns/10ps
// two stage synchroniser for pin inputs
module rbc_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input  wire logic             sys_clk,   // system clock
    input  wire logic             rst_n,     // async reset, low
    input  wire logic [WIDTH-1:0] asyncIn,   // raw pin levels
    output logic      [WIDTH-1:0] syncOut    // synchronised levels
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q  <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule : rbc_sync

// ### rtl/rbc_reset_backup.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
// Functional notes
// - reset pin low for one machine cycle or more causes a system reset
// - after reset pin release the core restarts at address zero, page zero
// - in reset ports float, output latches read one, pull-ups switched off
// - reset clears interrupt enable, power-down flag and external request flag
// - reset clears timer, watchdog, conversion-done and carry flags
// - reset loads clock control register with 1100
// - reset zeroes wakeup, pull-up, external irq and converter control registers
// - reset zeroes converter mode and input select register
// - retention entered only when sleep directly follows sleep-arm
// - sleep without sleep-arm just before it acts as no-operation
// - retention stops oscillation, keeps ram and reset circuit alive
// - skip instruction tests power-down flag for warm or cold start
// - wakeup signal in retention restarts at zero with power-down flag one
// - pin or watchdog reset restarts at zero with power-down flag zero
// - retained: ram, timer two/six, ext irq, converter, pull-up, wakeup
// - wake reinitialises pc, accumulators, carry, timer one, clock and irq control
// - wake reinitialises listed flags and watchdog counter; timer two kept
// - wake sets stack pointer to seven
// - retention keeps port levels but forces port c latch to one
// - enabled wakeup ports wake on low level, selectable per port
module rbc_reset_backup
    import rbc_pkg::*;
#(
    parameter int MC_DIV = MC_DIV_DEF
) (
    input  wire logic              sys_clk,        // system clock, 10 MHz
    input  wire logic              rst_n,          // power-on reset, low
    input  wire logic              resetPinN,      // external reset pin, low
    input  wire logic              intPin,         // int pin level
    input  wire logic [11:0]       wakePinN,       // key pins p0,p1,p2,d2,d3
    input  wire logic              wdtResetReq,    // watchdog reset pulse
    input  wire logic              instrValid,     // instruction executes
    input  wire rbc_instr_t        instrCode,      // decoded instruction
    input  rbc_flags_t             flagSet,        // hardware flag set pulses
    input  wire logic [ADDR_W-1:0] regAddr,        // register address
    input  wire logic [DATA_W-1:0] regWrData,      // write data
    input  wire logic              regWr,          // write strobe
    input  wire logic              regRd,          // read strobe
    output logic      [DATA_W-1:0] regRdData,      // read data, next cycle
    output logic                   coreResetN,     // core held while low
    output logic                   restartPulse,   // fetch from page 0 addr 0
    output logic                   pdFlag,         // power-down flag
    output logic                   skipNext,       // skip decision
    output logic      [2:0]        stackPtr,       // stack pointer
    output rbc_flags_t             flags,          // core flags
    output logic      [13:0][3:0]  ctrlRegs,       // control registers
    output logic      [15:0]       wdtCount,       // watchdog counter16
    output logic                   oscRun,         // oscillator enable
    output logic                   portHiZ,        // all ports floating
    output logic                   portLatchOne,   // force output latches
    output logic                   pullupOff,      // pull-ups off
    output logic                   portHold,       // port levels frozen
    output logic                   portCLatchOne   // shared c latch forced
);

    localparam int LCW = $clog2(MC_DIV + 1);
    localparam logic [LCW-1:0] LOW_FULL = LCW'(MC_DIV);

    rbc_state_t       state_q;
    rbc_state_t       state_d;
    logic [13:0]      pinSync;
    logic             resetS;
    logic             intS;
    logic [11:0]      keyS;
    logic [LCW-1:0]   lowCnt_q;
    logic [LCW-1:0]   mcCnt_q;
    logic             mcTick;
    logic             resetGo;
    logic             coldInit;
    logic             warmInit;
    logic             sleepGo;
    logic             wakeHit;
    logic             armed_q;
    logic [11:0]      keyEnable;
    logic [3:0]       ctrl_q [CTRL_NUM];
    logic             wdtWrap;
    logic             regWrOk;
    rbc_flags_t       flagBase;

    // decoded control register slot hit by the bus address
    function automatic logic slotHit(input logic [ADDR_W-1:0] addr, input int idx);
        slotHit = (addr == (ADDR_CTRL_BASE + ADDR_W'(idx * 4)));
    endfunction : slotHit

    // pins cross into the clock domain
    rbc_sync #(
        .WIDTH   (14),
        .RST_VAL (14'h3fff)
    ) uSync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .asyncIn ({resetPinN, intPin, wakePinN}),
        .syncOut (pinSync)
    );

    assign resetS = pinSync[13];
    assign intS   = pinSync[12];
    assign keyS   = pinSync[11:0];

    // machine cycle divider
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mcCnt_q <= '0;
        end else if (mcCnt_q == LCW'(MC_DIV - 1)) begin
            mcCnt_q <= '0;
        end else begin
            mcCnt_q <= mcCnt_q + 1'b1;
        end
    end

    assign mcTick = (mcCnt_q == LCW'(MC_DIV - 1));

    // measure how long the reset pin stays low, saturating at one machine cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt_q <= '0;
        end else if (resetS) begin
            lowCnt_q <= '0;
        end else if (lowCnt_q != LOW_FULL) begin
            lowCnt_q <= lowCnt_q + 1'b1;
        end
    end

    // a full machine cycle low or a watchdog reset starts a reset
    assign resetGo = (lowCnt_q == LOW_FULL) || wdtResetReq;

    // wake sources: per-port key enables, int pin on its chosen level
    assign keyEnable = {ctrl_q[IDX_WAKE_TWO], ctrl_q[IDX_WAKE_ONE], ctrl_q[IDX_WAKE_ZERO]};
    assign wakeHit = (|(~keyS & keyEnable))
                   || (!ctrl_q[IDX_WAKE_ONE][WAKE_ONE_SEL_BIT]
                       && (intS == ctrl_q[IDX_EXT_IRQ][EXT_IRQ_LEVEL_BIT]));

    // sleep only when armed by the instruction just before
    assign sleepGo = (state_q == ST_RUN) && instrValid
                   && (instrCode == INS_SLEEP_ENTER) && armed_q;

    // top level sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RESET: begin
                if (!resetGo) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleepGo) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wakeHit) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
        if (resetGo) begin
            state_d = ST_RESET;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign coldInit = (state_q == ST_RESET);
    assign warmInit = (state_q == ST_SLEEP) && wakeHit && !resetGo;
    assign regWrOk  = regWr && (state_q == ST_RUN);

    // restart strobe for the core, both warm and cold
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            restartPulse <= 1'b0;
        end else begin
            restartPulse <= (coldInit && !resetGo) || warmInit;
        end
    end

    // sleep arm latch, dropped by any other executed instruction
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (state_q != ST_RUN) begin
            armed_q <= 1'b0;
        end else if (instrValid) begin
            armed_q <= (instrCode == INS_SLEEP_ARM);
        end
    end

    // power-down flag: set on retention entry, cleared by cold start
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pdFlag <= 1'b0;
        end else if (coldInit) begin
            pdFlag <= 1'b0;
        end else if (sleepGo) begin
            pdFlag <= 1'b1;
        end
    end

    // skip decision for the power-down test instruction
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            skipNext <= 1'b0;
        end else begin
            skipNext <= instrValid && (instrCode == INS_SKIP_PD) && pdFlag;
        end
    end

    // stack pointer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stackPtr <= STACK_INIT;
        end else if (coldInit || warmInit) begin
            stackPtr <= STACK_INIT;
        end else if (regWrOk && regAddr == ADDR_STACK) begin
            stackPtr <= regWrData[2:0];
        end
    end

    // control registers, kept or reloaded on wake by slot
    generate
        for (genvar i = 0; i < CTRL_NUM; i++) begin : gCtrl
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_q[i] <= CTRL_RST_VEC[i*4 +: 4];
                end else if (coldInit) begin
                    ctrl_q[i] <= CTRL_RST_VEC[i*4 +: 4];
                end else if (warmInit && !CTRL_RETAIN[i]) begin
                    ctrl_q[i] <= CTRL_RST_VEC[i*4 +: 4];
                end else if (regWrOk && slotHit(regAddr, i)) begin
                    ctrl_q[i] <= regWrData[3:0];
                end
            end
            assign ctrlRegs[i] = ctrl_q[i];
        end
    endgenerate

    // watchdog counter16 on machine cycles
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdtCount <= WDT_RST;
        end else if (coldInit || warmInit) begin
            wdtCount <= WDT_RST;
        end else if (instrValid && instrCode == INS_WDT_RESTART) begin
            wdtCount <= WDT_RST;
        end else if (state_q == ST_RUN && flags.wdEnable && mcTick) begin
            wdtCount <= wdtCount + 1'b1;
        end
    end

    assign wdtWrap = (state_q == ST_RUN) && flags.wdEnable && mcTick && (wdtCount == WDT_TOP);

    // flag value before hardware sets are merged
    always_comb begin
        flagBase = flags;
        if (regWrOk && regAddr == ADDR_FLAGS) begin
            flagBase = rbc_flags_t'(regWrData[8:0]);
        end
        if (instrValid && instrCode == INS_WDT_RESTART) begin
            flagBase.wdFirst = 1'b0;
        end
    end

    // core flags; a hardware set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= rbc_flags_t'(FLAG_RST);
        end else if (coldInit) begin
            flags <= rbc_flags_t'(FLAG_RST);
        end else if (warmInit) begin
            flags <= rbc_flags_t'(flags & FLAG_WARM_KEEP);
        end else if (state_q == ST_RUN) begin
            flags         <= flagBase | flagSet;
            flags.wdFirst <= flagBase.wdFirst | flagSet.wdFirst | wdtWrap;
        end
    end

    // read data, one cycle after the strobe, zero when unmapped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= '0;
        end else if (regRd) begin
            regRdData <= '0;
            for (int i = 0; i < CTRL_NUM; i++) begin
                if (slotHit(regAddr, i)) begin
                    regRdData <= {12'h000, ctrl_q[i]};
                end
            end
            if (regAddr == ADDR_FLAGS) begin
                regRdData <= {7'h00, flags};
            end
            if (regAddr == ADDR_STATUS) begin
                regRdData <= {12'h000, state_q, armed_q, pdFlag};
            end
            if (regAddr == ADDR_STACK) begin
                regRdData <= {13'h0000, stackPtr};
            end
            if (regAddr == ADDR_WDT) begin
                regRdData <= wdtCount;
            end
        end else begin
            regRdData <= '0;
        end
    end

    // pin and clock controls follow the state
    assign coreResetN    = (state_q != ST_RESET);
    assign portHiZ       = (state_q == ST_RESET);
    assign portLatchOne  = (state_q == ST_RESET);
    assign pullupOff     = (state_q == ST_RESET);
    assign oscRun        = (state_q != ST_SLEEP);
    assign portHold      = (state_q == ST_SLEEP);
    assign portCLatchOne = (state_q == ST_SLEEP);

    sequence s_armed;
        instrValid && instrCode == INS_SLEEP_ARM && state_q == ST_RUN && !resetGo;
    endsequence

    sequence s_enter;
        instrValid && instrCode == INS_SLEEP_ENTER && !resetGo;
    endsequence

    a_reset_detect: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (lowCnt_q == LOW_FULL) |=> (state_q == ST_RESET) && !coreResetN)
        else $error("reset pin low a full cycle did not reset");

    a_cold_values: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(state_q == ST_RESET) |=> flags == rbc_flags_t'(FLAG_RST)
            && ctrl_q[IDX_CLOCK_CTRL] == CLOCK_CTRL_RST && ctrl_q[IDX_WAKE_ZERO] == ZERO_RST)
        else $error("reset values not loaded");

    a_cold_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rst_n && state_q == ST_RESET && !resetGo) |=> restartPulse && !pdFlag && state_q == ST_RUN)
        else $error("cold restart wrong");

    a_sleep_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_armed ##1 s_enter |=> state_q == ST_SLEEP && pdFlag)
        else $error("armed sleep did not enter retention");

    a_sleep_nop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == ST_RUN && !armed_q) ##0 s_enter |=> state_q == ST_RUN)
        else $error("unarmed sleep was not a no-op");

    a_sleep_osc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == ST_SLEEP |-> !oscRun && portCLatchOne && coreResetN)
        else $error("retention outputs wrong");

    a_warm_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
        warmInit |=> restartPulse && pdFlag && stackPtr == STACK_INIT
            && !flags.irqEnable && wdtCount == WDT_RST)
        else $error("warm restart wrong");

    a_wake_retain: assert property (@(posedge sys_clk) disable iff (!rst_n)
        warmInit |=> ctrl_q[IDX_WAKE_ONE] == $past(ctrl_q[IDX_WAKE_ONE])
            && ctrl_q[IDX_PU_TWO] == $past(ctrl_q[IDX_PU_TWO])
            && flags.tmr2Req == $past(flags.tmr2Req))
        else $error("retained state lost on wake");

    a_wdt_cold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wdtResetReq && resetS && state_q == ST_RUN) |-> ##[1:3] (restartPulse && !pdFlag))
        else $error("watchdog reset did not cold start");

    a_skip_pd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (instrValid && instrCode == INS_SKIP_PD) |=> skipNext == $past(pdFlag))
        else $error("skip does not follow power-down flag");

endmodule : rbc_reset_backup

// ### testbench/rbc_ext_model.sv
`timescale 1ns/10ps
// external reset circuit and key switches
module rbc_ext_model #(
    parameter int HOLD = 12
) (
    input  wire logic        sys_clk,    // system clock
    input  wire logic        resetGo,    // start a reset pulse
    input  wire logic [11:0] keyLow,     // keys pressed
    input  wire logic        intLow,     // int pin pulled low
    output logic             resetPinN,  // reset pin, low
    output logic      [11:0] wakePinN,   // key pins, low wakes
    output logic             intPin      // int pin level
);
    logic [7:0] cnt = 8'h00;
    // pin held low well beyond one machine cycle
    always_ff @(posedge sys_clk) begin
        if (resetGo) begin
            cnt <= 8'(HOLD);
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
    assign resetPinN = (cnt == 8'h00);
    // idle keys stay high so sleep is entered cleanly
    assign wakePinN  = ~keyLow;
    assign intPin    = ~intLow;
endmodule : rbc_ext_model

// ### testbench/tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
    import rbc_pkg::*;
    localparam int MCD = 2;
    logic sys_clk = 0, rst_n = 0, instrValid = 0, regWr = 0, regRd = 0, resetGo = 0, rdDly = 0;
    logic wdtReq = 0, intLow = 0;
    rbc_flags_t       flagsOut;
    logic [13:0][3:0] ctrlOut;
    logic [15:0]      wdtOut;
    logic resetPinN, intPin, coreResetN, restartPulse, pdFlag, skipNext, oscRun;
    logic portHiZ, portLatchOne, pullupOff, portHold, portCLatchOne;
    logic [11:0] wakePinN, keyLow = '0;
    logic [7:0]  regAddr = '0;
    logic [15:0] regWrData = '0, regRdData, e;
    logic [2:0]  stackPtr;
    logic [3:0]  rv;
    rbc_instr_t  instrCode = INS_OTHER;
    logic [15:0] expQ[$];
    int err_total = 0, check_count = 0, cyc = 0;

    rbc_ext_model #(.HOLD(4 * MCD + 4)) rbc_ext_model_inst (.sys_clk(sys_clk), .resetGo(resetGo),
        .keyLow(keyLow), .intLow(intLow), .resetPinN(resetPinN), .wakePinN(wakePinN), .intPin(intPin));
    rbc_reset_backup #(.MC_DIV(MCD)) rbc_reset_backup_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .resetPinN(resetPinN), .intPin(intPin), .wakePinN(wakePinN), .wdtResetReq(wdtReq),
        .instrValid(instrValid), .instrCode(instrCode), .flagSet('0), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .coreResetN(coreResetN), .restartPulse(restartPulse), .pdFlag(pdFlag), .skipNext(skipNext),
        .stackPtr(stackPtr), .flags(flagsOut), .ctrlRegs(ctrlOut), .wdtCount(wdtOut),
        .oscRun(oscRun), .portHiZ(portHiZ),
        .portLatchOne(portLatchOne), .pullupOff(pullupOff), .portHold(portHold),
        .portCLatchOne(portCLatchOne));

    // clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    // read monitor, oldest note against read data
    always @(posedge sys_clk) rdDly <= regRd;
    always @(negedge sys_clk) begin
        if (rdDly) begin
            e = expQ.pop_front();
            `CHK("regRdData", e, regRdData)
        end
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk); regWr <= 1'b1; regAddr <= a; regWrData <= d;
        @(posedge sys_clk); regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk); regRd <= 1'b1; regAddr <= a; expQ.push_back(d);
        @(posedge sys_clk); regRd <= 1'b0;
    endtask : rd
    task automatic prog(input rbc_instr_t c[]);
        foreach (c[i]) begin
            @(posedge sys_clk); instrValid <= 1'b1; instrCode <= c[i];
        end
        @(posedge sys_clk); instrValid <= 1'b0;
    endtask : prog
    task automatic wait_restart();
        for (int n = 0; n < 40 && restartPulse !== 1'b1; n++) @(negedge sys_clk);
        `CHK("restartPulse", 1'b1, restartPulse)
    endtask : wait_restart
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        void'($urandom(19698));
        repeat (3) @(posedge sys_clk);
        `CHK("coreResetN", 1'b0, coreResetN)
        `CHK("portsReset", 3'b111, {portHiZ, portLatchOne, pullupOff})
        rst_n <= 1'b1;
        wait_restart();
        `CHK("pdFlag", 1'b0, pdFlag)
        `CHK("ctrlClock", 4'hc, ctrlOut[IDX_CLOCK_CTRL])
        for (int i = 0; i < CTRL_NUM; i++) rd(8'(4 * i), (i == 0) ? 16'h000c : 16'h0000);
        rd(ADDR_FLAGS, 16'h0000);
        rd(8'h50, 16'h0000);
        $display("test cold reset values done");
        rv = 4'($urandom());
        wr(8'h2c, {12'h000, rv});
        wr(8'h20, 16'h0001);
        wr(8'h00, 16'h0003);
        wr(ADDR_FLAGS, 16'h01ff);
        prog('{INS_SLEEP_ENTER});
        prog('{INS_SLEEP_ARM, INS_OTHER, INS_SLEEP_ENTER});
        @(negedge sys_clk);
        `CHK("noSleep", 2'b10, {oscRun, pdFlag})
        prog('{INS_WDT_RESTART, INS_SLEEP_ARM, INS_SLEEP_ENTER});
        @(negedge sys_clk);
        `CHK("oscRun", 1'b0, oscRun)
        `CHK("sleepPorts", 2'b11, {portHold, portCLatchOne})
        wr(8'h2c, {12'h000, ~rv});
        @(posedge sys_clk); keyLow <= 12'h001;
        wait_restart();
        @(posedge sys_clk); keyLow <= 12'h000;
        `CHK("pdFlag", 1'b1, pdFlag)
        `CHK("stackPtr", 3'h7, stackPtr)
        `CHK("flags", 9'h028, flagsOut)
        `CHK("wdtCount", 16'h0000, wdtOut)
        `CHK("ctrlPu0", rv, ctrlOut[IDX_PU_ZERO])
        rd(8'h00, 16'h000c);
        rd(ADDR_FLAGS, 16'h0028);
        rd(ADDR_WDT, 16'h0000);
        rd(8'h2c, {12'h000, rv});
        rd(8'h20, 16'h0001);
        wr(ADDR_FLAGS, 16'h0000);
        prog('{INS_SKIP_PD});
        @(negedge sys_clk);
        `CHK("skipNext", 1'b1, skipNext)
        $display("test ram retention done");
        @(posedge sys_clk); resetGo <= 1'b1;
        @(posedge sys_clk); resetGo <= 1'b0;
        repeat (10) @(negedge sys_clk);
        `CHK("coreResetN", 1'b0, coreResetN)
        `CHK("portHiZ", 1'b1, portHiZ)
        wait_restart();
        `CHK("pdFlag", 1'b0, pdFlag)
        rd(8'h2c, 16'h0000);
        rd(8'h00, 16'h000c);
        prog('{INS_SKIP_PD});
        @(negedge sys_clk);
        `CHK("skipNext", 1'b0, skipNext)
        $display("test pin reset done");
        prog('{INS_SLEEP_ARM, INS_SLEEP_ENTER});
        @(posedge sys_clk); intLow <= 1'b1;
        wait_restart();
        @(posedge sys_clk); intLow <= 1'b0;
        `CHK("pdFlagInt", 1'b1, pdFlag)
        @(posedge sys_clk); wdtReq <= 1'b1;
        @(posedge sys_clk); wdtReq <= 1'b0;
        wait_restart();
        `CHK("pdFlagWdt", 1'b0, pdFlag)
        rd(ADDR_STATUS, 16'h0004);
        $display("test watchdog reset done");
        repeat (3) @(posedge sys_clk);
        report_and_stop();
    end
endmodule : tb
